// ==== src/rcs_dev.sv ====
// Clock device end: timekeeping, calibration, test tone and write port.
// Operation
// (RL1) Timekeeping counts a 32768 Hz oscillator.
// (RL2) Control holds magnitude bits 0-4, sign bit 5.
// (RL3) Sign one speeds up, zero slows down.
// (RL4) Step is 4.068 or 2.034 ppm.
// (RL5) Test flag makes seconds bit 0 toggle 512 Hz.
// (RL6) Long unfrozen seconds read shows tone on line 0.
// (RL7) Host sets test flag only under time-set.
// (RL8) Clearing test flag restores normal seconds reads.
// (RL9) Oscillator halt flag is one after reset.
// (RL10) Write starts at later of select/strobe falling.
// (RL11) Write ends at first select/strobe rising.
// (RL12) Select falling with strobe low keeps outputs off.
// (RL13) Host holds select or strobe high on address change.
// (RL14) Host never fights device-driven data during writes.
// (RL15) Output strobe high keeps data lines undriven.
// (RL16) Time-set freezes copy; clearing loads counters.
// (RL17) Freeze-read stops copy, counters keep running.
// (RL18) Calibration adds or drops prescaler counts per minute.
`timescale 1ns/100ps
module rcs_dev
  import rcs_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  rcs_if.dev                            bus,
  output logic [SEC_BCD_W-1:0]          seconds_count,
  output logic                          second_pulse,
  output logic                          crystal_halt
);
  import rcs_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  localparam int PIN_W = ADDR_W + 3 + DATA_W;
  // Both stages reset to the idle pin levels, so release cannot fake a select.
  localparam logic [PIN_W-1:0] PIN_IDLE =
    {{ADDR_W{1'b0}}, 3'b111, {DATA_W{1'b1}}};
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  wire  [PIN_W-1:0] pin_raw = {bus.addr, bus.chip_sel_n, bus.wr_strobe_n,
                               bus.out_strobe_n, bus.dq_bus};

  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      pin_meta_reg <= PIN_IDLE;
      pin_sync_reg <= PIN_IDLE;
    end
    else
    begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end

  wire [ADDR_W-1:0] addr_s = pin_sync_reg[PIN_W-1 -: ADDR_W];
  wire              cs_n_s = pin_sync_reg[DATA_W+2];
  wire              we_n_s = pin_sync_reg[DATA_W+1];
  wire              oe_n_s = pin_sync_reg[DATA_W];
  wire [DATA_W-1:0] dq_s   = pin_sync_reg[DATA_W-1:0];

  // ==========================================================================
  // Write cycle tracking
  // ==========================================================================
  logic              wr_act_reg;
  logic              cs_n_prev_reg;
  logic              out_block_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [DATA_W-1:0] wr_data_reg;

  // (RL10) Both strobes low
  wire wr_act    = !cs_n_s && !we_n_s;
  // (RL11) First rising ends
  wire wr_commit = wr_act_reg && !wr_act;
  wire cs_fall   = cs_n_prev_reg && !cs_n_s;

  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      wr_act_reg    <= 1'b0;
      cs_n_prev_reg <= 1'b1;
      out_block_reg <= 1'b0;
      wr_addr_reg   <= '0;
      wr_data_reg   <= '0;
    end
    else
    begin
      wr_act_reg    <= wr_act;
      cs_n_prev_reg <= cs_n_s;
      // (RL12) Late select blocks output
      if (cs_n_s)
        out_block_reg <= 1'b0;
      else if (cs_fall && !we_n_s)
        out_block_reg <= 1'b1;
      // Data is taken at the last active sample so it meets setup to end.
      if (wr_act)
      begin
        wr_addr_reg <= addr_s;
        wr_data_reg <= dq_s;
      end
    end

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [DATA_W-1:0]    ctrl_reg;
  logic [DATA_W-1:0]    sec_vis_reg;
  logic [DATA_W-1:0]    days_reg;
  logic                 time_set_prev_reg;

  // (RL2) Magnitude and sign fields
  wire [CAL_MAG_W-1:0] calib_magnitude = ctrl_reg[CAL_MAG_W-1:0];
  wire calib_sign       = ctrl_reg[CAL_SIGN_BIT];
  wire freeze_read_flag = ctrl_reg[FREEZE_BIT];
  wire time_set_flag    = ctrl_reg[TIME_SET_BIT];
  wire freq_test_flag   = days_reg[FTEST_BIT];
  wire ts_release       = time_set_prev_reg && !time_set_flag;
  wire wr_ctrl = wr_commit && (wr_addr_reg == ADDR_CONTROL);
  wire wr_sec  = wr_commit && (wr_addr_reg == ADDR_SECONDS);
  wire wr_days = wr_commit && (wr_addr_reg == ADDR_DAYS);

  // ==========================================================================
  // Oscillator, prescaler and seconds counter
  // ==========================================================================
  logic [ACC_W-1:0]     acc_reg;
  logic [PRESC_W-1:0]   presc_reg;
  logic [SEC_BCD_W-1:0] sec_int_reg;
  logic                 sec_tick_reg;

  function automatic logic [SEC_BCD_W-1:0] bcd_sec_inc(
    input logic [SEC_BCD_W-1:0] v
  );
    logic [SEC_BCD_W-1:0] r;
    r = v;
    if (v[3:0] != 4'h9)
      r[3:0] = v[3:0] + 4'h1;
    else
    begin
      r[3:0] = 4'h0;
      r[6:4] = (v[6:4] == 3'h5) ? 3'h0 : v[6:4] + 3'h1;
    end
    return r;
  endfunction : bcd_sec_inc

  // (RL1) 32768 Hz from the core clock
  wire [ACC_W-1:0] acc_sum  = acc_reg + ACC_INC;
  wire             osc_wrap = acc_sum >= ACC_MOD;
  wire             osc_tick = osc_wrap && !crystal_halt;
  wire [ACC_W-1:0] acc_next = osc_wrap ? acc_sum - ACC_MOD : acc_sum;

  // (RL18) Correction in the first second of each minute
  wire [PRESC_W-1:0] mag_ext   = PRESC_W'(calib_magnitude);
  wire [PRESC_W-1:0] pos_delta = PRESC_W'(mag_ext * CAL_POS_STEP);
  wire [PRESC_W-1:0] neg_delta = PRESC_W'(mag_ext * CAL_NEG_STEP);
  // (RL3) Positive drops counts, negative adds
  // (RL4) Eight or four counts per 60 s step
  wire [PRESC_W-1:0] cal_top   = calib_sign ? PRESC_TOP - pos_delta
                                            : PRESC_TOP + neg_delta;
  wire [PRESC_W-1:0] presc_top = (sec_int_reg == '0) ? cal_top : PRESC_TOP;
  wire               presc_end = osc_tick && (presc_reg >= presc_top);

  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      acc_reg      <= '0;
      presc_reg    <= '0;
      sec_int_reg  <= '0;
      sec_tick_reg <= 1'b0;
    end
    else
    begin
      acc_reg      <= acc_next;
      sec_tick_reg <= presc_end;
      // (RL16) Release loads counters
      if (ts_release)
      begin
        presc_reg   <= '0;
        sec_int_reg <= sec_vis_reg[SEC_BCD_W-1:0];
      end
      else if (presc_end)
      begin
        presc_reg   <= '0;
        sec_int_reg <= bcd_sec_inc(sec_int_reg);
      end
      else if (osc_tick)
        presc_reg <= presc_reg + 16'h0001;
    end

  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      ctrl_reg          <= CTRL_RESET;
      // (RL9) Oscillator halted from reset
      sec_vis_reg       <= SEC_RESET;
      days_reg          <= DAYS_RESET;
      time_set_prev_reg <= 1'b0;
    end
    else
    begin
      time_set_prev_reg <= time_set_flag;
      if (wr_ctrl)
        ctrl_reg <= wr_data_reg;
      if (wr_days)
        days_reg <= wr_data_reg;
      // A host write beats a same-cycle copy so set values are not lost.
      if (wr_sec)
        sec_vis_reg <= wr_data_reg;
      // (RL17) Freeze and time-set stop the copy
      else if (sec_tick_reg && !freeze_read_flag && !time_set_flag)
        sec_vis_reg[SEC_BCD_W-1:0] <= sec_int_reg;
    end

  assign crystal_halt  = sec_vis_reg[HALT_BIT];
  assign seconds_count = sec_int_reg;
  assign second_pulse  = sec_tick_reg;

  // ==========================================================================
  // Read path
  // ==========================================================================
  logic [DATA_W-1:0] rd_data_reg;
  logic              rd_oe_reg;

  // (RL5) Test tone replaces seconds bit 0
  // (RL8) Cleared flag gives plain seconds
  wire test_on  = freq_test_flag && !freeze_read_flag;
  wire [DATA_W-1:0] sec_view = test_on ?
    {sec_vis_reg[DATA_W-1:1], presc_reg[TEST_TAP]} : sec_vis_reg;
  // (RL6) Tone reaches data_line_zero
  wire [DATA_W-1:0] rd_mux =
    (addr_s == ADDR_SECONDS) ? sec_view :
    (addr_s == ADDR_CONTROL) ? ctrl_reg :
    (addr_s == ADDR_DAYS)    ? days_reg : 8'h00;
  // (RL15) Output strobe high never drives
  wire rd_drive = !cs_n_s && !oe_n_s && we_n_s && !out_block_reg;

  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      rd_data_reg <= '0;
      rd_oe_reg   <= 1'b0;
    end
    else
    begin
      rd_data_reg <= rd_mux;
      rd_oe_reg   <= rd_drive;
    end

  assign bus.dev_dq_out = rd_data_reg;
  assign bus.dev_dq_oe  = rd_oe_reg;

endmodule : rcs_dev

// ==== src/rcs_pkg.sv ====
// Shared constants for the clock calibration block and its SRAM-style port.
package rcs_pkg;

  // ==========================================================================
  // Bus geometry and register map
  // ==========================================================================
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 19'h7fff8;
  localparam logic [ADDR_W-1:0] ADDR_SECONDS = 19'h7fff9;
  localparam logic [ADDR_W-1:0] ADDR_DAYS    = 19'h7fffc;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int CAL_MAG_W     = 5;
  localparam int CAL_SIGN_BIT  = 5;
  localparam int FREEZE_BIT    = 6;
  localparam int TIME_SET_BIT  = 7;
  localparam int HALT_BIT      = 7;
  localparam int FTEST_BIT     = 6;
  localparam int SEC_BCD_W     = 7;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SEC_RESET  = 8'h80;
  localparam logic [DATA_W-1:0] DAYS_RESET = 8'h01;

  // ==========================================================================
  // Timekeeping constants
  // ==========================================================================
  localparam int CORE_HZ = 100_000_000;
  localparam int OSC_HZ  = 32_768;
  localparam int ACC_W   = 27;
  localparam logic [ACC_W-1:0] ACC_MOD = 27'(CORE_HZ);
  localparam logic [ACC_W-1:0] ACC_INC = 27'(OSC_HZ);
  localparam int PRESC_W = 16;
  localparam logic [PRESC_W-1:0] PRESC_TOP = 16'(OSC_HZ - 1);
  // Prescaler bit that toggles at 512 Hz from a 32768 Hz count.
  localparam int TEST_TAP = 5;
  // Counts per magnitude step over the 60 s correction period.
  localparam logic [PRESC_W-1:0] CAL_POS_STEP = 16'h0008;
  localparam logic [PRESC_W-1:0] CAL_NEG_STEP = 16'h0004;

  // ==========================================================================
  // Host strobe timing
  // ==========================================================================
  localparam int CLK_NS  = 10;
  localparam int T_WP_NS = 65;
  localparam int T_RC_NS = 85;
  localparam int T_WR_NS = 15;
  localparam int PIPE_LAT = 6;
  localparam int CNT_W   = 5;
  localparam logic [CNT_W-1:0] WR_CYC =
    CNT_W'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RD_CYC =
    CNT_W'((T_RC_NS + CLK_NS - 1) / CLK_NS + PIPE_LAT);
  localparam logic [CNT_W-1:0] REC_CYC =
    CNT_W'((T_WR_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    RCS_IDLE,
    RCS_SETUP,
    RCS_STROBE,
    RCS_HOLD,
    RCS_RECOV
  } rcs_hstate_e;

endpackage : rcs_pkg

// ==== src/rcs_if.sv ====
// SRAM-style pin bundle joining host and clock device.
`timescale 1ns/100ps
interface rcs_if;
  import rcs_pkg::*;

  logic [ADDR_W-1:0] addr;
  logic              chip_sel_n;
  logic              wr_strobe_n;
  logic              out_strobe_n;
  logic [DATA_W-1:0] host_dq_out;
  logic              host_dq_oe;
  logic [DATA_W-1:0] dev_dq_out;
  logic              dev_dq_oe;
  logic [DATA_W-1:0] dq_bus;

  // Undriven data lines float high, as with a weak pull-up.
  assign dq_bus = dev_dq_oe  ? dev_dq_out :
                  host_dq_oe ? host_dq_out : 8'hff;

  modport dev (
    input  addr, chip_sel_n, wr_strobe_n, out_strobe_n, dq_bus,
    output dev_dq_out, dev_dq_oe
  );
  modport host (
    output addr, chip_sel_n, wr_strobe_n, out_strobe_n,
    output host_dq_out, host_dq_oe,
    input  dq_bus
  );
endinterface : rcs_if

// ==== src/rcs_host.sv ====
// Host end: turns user commands into SRAM-style strobe cycles.
`timescale 1ns/100ps
module rcs_host
  import rcs_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  rcs_if.host                           bus,
  input  wire logic                     cmd_valid,
  input  wire logic                     cmd_write,
  input  wire logic [ADDR_W-1:0]        cmd_addr,
  input  wire logic [DATA_W-1:0]        cmd_wdata,
  input  wire logic                     cmd_hold,
  output logic                          cmd_ready,
  output logic                          rsp_valid,
  output logic [DATA_W-1:0]             rsp_rdata,
  output logic                          rsp_refused,
  output logic                          data_line_zero
);
  import rcs_pkg::*;

  // ==========================================================================
  // Data line synchroniser
  // ==========================================================================
  logic [DATA_W-1:0] dq_meta_reg;
  logic [DATA_W-1:0] dq_sync_reg;

  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      dq_meta_reg <= '0;
      dq_sync_reg <= '0;
    end
    else
    begin
      dq_meta_reg <= bus.dq_bus;
      dq_sync_reg <= dq_meta_reg;
    end

  // ==========================================================================
  // Cycle sequencer
  // ==========================================================================
  rcs_hstate_e       st_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              is_wr_reg;
  logic              ts_shadow_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic              cs_n_reg;
  logic              we_n_reg;
  logic              oe_n_reg;
  logic              dq_oe_reg;
  logic              rsp_valid_reg;
  logic              rsp_refused_reg;
  logic [DATA_W-1:0] rsp_rdata_reg;
  logic              probe_reg;

  // (RL7) Test flag only under time-set
  wire bad_ftest = cmd_write && (cmd_addr == ADDR_DAYS) &&
                   cmd_wdata[FTEST_BIT] && !ts_shadow_reg;
  wire take      = cmd_valid && (st_reg == RCS_IDLE);
  wire last_cnt  = (cnt_reg == '0);

  assign cmd_ready = (st_reg == RCS_IDLE);

  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      st_reg          <= RCS_IDLE;
      cnt_reg         <= '0;
      is_wr_reg       <= 1'b0;
      ts_shadow_reg   <= 1'b0;
      addr_reg        <= '0;
      wdata_reg       <= '0;
      cs_n_reg        <= 1'b1;
      we_n_reg        <= 1'b1;
      oe_n_reg        <= 1'b1;
      dq_oe_reg       <= 1'b0;
      rsp_valid_reg   <= 1'b0;
      rsp_refused_reg <= 1'b0;
      rsp_rdata_reg   <= '0;
      probe_reg       <= 1'b0;
    end
    else
    begin
      rsp_valid_reg   <= 1'b0;
      rsp_refused_reg <= 1'b0;
      probe_reg       <= dq_sync_reg[0];
      unique case (st_reg)
        RCS_IDLE:
          if (take && bad_ftest)
          begin
            rsp_valid_reg   <= 1'b1;
            rsp_refused_reg <= 1'b1;
          end
          else if (take)
          begin
            // (RL13) Address moves only while strobes are high
            addr_reg  <= cmd_addr;
            wdata_reg <= cmd_wdata;
            is_wr_reg <= cmd_write;
            // (RL14) Write data only with output strobe high
            dq_oe_reg <= cmd_write;
            if (cmd_write && (cmd_addr == ADDR_CONTROL))
              ts_shadow_reg <= cmd_wdata[TIME_SET_BIT];
            st_reg    <= RCS_SETUP;
          end
        RCS_SETUP:
        begin
          cs_n_reg <= 1'b0;
          we_n_reg <= !is_wr_reg;
          oe_n_reg <= is_wr_reg;
          cnt_reg  <= (is_wr_reg ? WR_CYC : RD_CYC) - 5'h01;
          st_reg   <= RCS_STROBE;
        end
        RCS_STROBE:
          if (!last_cnt)
            cnt_reg <= cnt_reg - 5'h01;
          // (RL6) Held read keeps the tone visible
          else if (!is_wr_reg && cmd_hold)
          begin
            rsp_rdata_reg <= dq_sync_reg;
            rsp_valid_reg <= 1'b1;
            st_reg        <= RCS_HOLD;
          end
          else
          begin
            rsp_rdata_reg <= is_wr_reg ? wdata_reg : dq_sync_reg;
            rsp_valid_reg <= 1'b1;
            cs_n_reg      <= 1'b1;
            we_n_reg      <= 1'b1;
            oe_n_reg      <= 1'b1;
            cnt_reg       <= REC_CYC - 5'h01;
            st_reg        <= RCS_RECOV;
          end
        RCS_HOLD:
          if (!cmd_hold)
          begin
            cs_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            cnt_reg  <= REC_CYC - 5'h01;
            st_reg   <= RCS_RECOV;
          end
        RCS_RECOV:
          // Data stays driven through recovery to cover the hold time.
          if (!last_cnt)
            cnt_reg <= cnt_reg - 5'h01;
          else
          begin
            dq_oe_reg <= 1'b0;
            st_reg    <= RCS_IDLE;
          end
      endcase
    end

  assign bus.addr         = addr_reg;
  assign bus.chip_sel_n   = cs_n_reg;
  assign bus.wr_strobe_n  = we_n_reg;
  assign bus.out_strobe_n = oe_n_reg;
  assign bus.host_dq_out  = wdata_reg;
  assign bus.host_dq_oe   = dq_oe_reg;
  assign rsp_valid        = rsp_valid_reg;
  assign rsp_refused      = rsp_refused_reg;
  assign rsp_rdata        = rsp_rdata_reg;
  assign data_line_zero   = probe_reg;

endmodule : rcs_host

// ==== sim/rcs_monitor.sv ====
// Concurrent checks on the SRAM-style pins between host and clock device.
`timescale 1ns/100ps
module rcs_monitor
  import rcs_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic [ADDR_W-1:0]        addr,
  input  wire logic                     chip_sel_n,
  input  wire logic                     wr_strobe_n,
  input  wire logic                     out_strobe_n,
  input  wire logic [DATA_W-1:0]        host_dq_out,
  input  wire logic                     host_dq_oe,
  input  wire logic                     dev_dq_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Strobe sequences
  // ==========================================================================
  // Five cycles cover the two sync flops plus the device output register.
  sequence write_held_s;
    (!chip_sel_n && !wr_strobe_n) [*5];
  endsequence
  sequence read_held_s;
    (!chip_sel_n && !out_strobe_n && wr_strobe_n) [*5];
  endsequence
  sequence write_pulse_s;
    (!chip_sel_n && !wr_strobe_n) [*7] ##1 (chip_sel_n && wr_strobe_n);
  endsequence

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // idle output strobe
  a_oe_idle_off: assert property (out_strobe_n [*5] |-> !dev_dq_oe)
    else $error("device drives data while output strobe is high");
  a_write_hiz: assert property (write_held_s |-> !dev_dq_oe)
    else $error("device drives data during a write");
  a_read_drive: assert property (read_held_s |-> dev_dq_oe)
    else $error("device silent during a selected read");
  a_no_contention: assert property (!(host_dq_oe && dev_dq_oe))
    else $error("host and device drive data together");
  a_write_pulse: assert property ($fell(wr_strobe_n) |-> write_pulse_s)
    else $error("write pulse has wrong length or strobes end apart");
  a_wr_data_en: assert property (!wr_strobe_n |-> host_dq_oe && out_strobe_n)
    else $error("write strobe low without host data or with output on");
  a_wr_data_hold: assert property
    (!wr_strobe_n && !$past(wr_strobe_n) |-> $stable(host_dq_out))
    else $error("write data changed inside a write");
  a_addr_steady: assert property
    (!chip_sel_n && !wr_strobe_n && !$past(chip_sel_n) &&
     !$past(wr_strobe_n) |-> $stable(addr))
    else $error("address changed while a write was active");
  a_wr_recover: assert property
    ($rose(wr_strobe_n) |-> (chip_sel_n && host_dq_oe) [*2])
    else $error("write recovery or data hold too short");
endmodule : rcs_monitor

// ==== sim/rcs_tb.sv ====
// Self-checking bench joining the host end and the clock device end.
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
      $display("BAD %0t got %h expected %h", $time, got, exp); \
    if ((got) !== (exp)) \
      fails++; \
  end
module rcs_tb;
  import rcs_pkg::*;
  logic              core_clk;
  logic              sys_rst;
  logic              cmd_valid;
  logic              cmd_write;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_wdata;
  logic              cmd_hold;
  logic              cmd_ready;
  logic              rsp_valid;
  logic [DATA_W-1:0] rsp_rdata;
  logic              rsp_refused;
  logic              data_line_zero;
  logic              crystal_halt;
  logic [SEC_BCD_W-1:0] sec_cnt;
  logic              sec_pulse;
  logic [9:0]        exp_q[$];
  logic [9:0]        exp_e;
  logic [31:0]       rnd;
  logic [DATA_W-1:0] ctl_v;
  int                fails;
  int                cmp_count;
  int                cyc;

  rcs_if bus_if ();
  rcs_host rcs_host_inst (
    .core_clk       (core_clk),
    .sys_rst        (sys_rst),
    .bus            (bus_if),
    .cmd_valid      (cmd_valid),
    .cmd_write      (cmd_write),
    .cmd_addr       (cmd_addr),
    .cmd_wdata      (cmd_wdata),
    .cmd_hold       (cmd_hold),
    .cmd_ready      (cmd_ready),
    .rsp_valid      (rsp_valid),
    .rsp_rdata      (rsp_rdata),
    .rsp_refused    (rsp_refused),
    .data_line_zero (data_line_zero)
  );
  rcs_dev rcs_dev_inst (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .bus           (bus_if),
    .seconds_count (sec_cnt),
    .second_pulse  (sec_pulse),
    .crystal_halt  (crystal_halt)
  );
  rcs_monitor rcs_monitor_inst (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .addr         (bus_if.addr),
    .chip_sel_n   (bus_if.chip_sel_n),
    .wr_strobe_n  (bus_if.wr_strobe_n),
    .out_strobe_n (bus_if.out_strobe_n),
    .host_dq_out  (bus_if.host_dq_out),
    .host_dq_oe   (bus_if.host_dq_oe),
    .dev_dq_oe    (bus_if.dev_dq_oe)
  );

  // ==========================================================================
  // Clock, timeout and response checking
  // ==========================================================================
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic report_and_stop;
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      $display("BAD %0t run did not finish", $time);
      report_and_stop();
    end
  end

  // Expectation notes are {check data, refused, data}.
  always @(negedge core_clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      exp_e = (exp_q.size() == 0) ? 10'h3ff : exp_q.pop_front();
      `CHK(rsp_refused, exp_e[8])
      if (exp_e[9])
        `CHK(rsp_rdata, exp_e[7:0])
    end
  end

  // ==========================================================================
  // Command driver
  // ==========================================================================
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic do_cmd(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic hold,
                        input logic [9:0] e);
    @(negedge core_clk);
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr  = a;
    cmd_wdata = d;
    cmd_hold  = hold;
    exp_q.push_back(e);
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask : do_cmd

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    do_cmd(1'b1, a, d, 1'b0, {2'b10, d});
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    do_cmd(1'b0, a, 8'h00, 1'b0, {2'b10, x});
  endtask : rd

  initial
  begin
    sys_rst   = 1'b1;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr  = '0;
    cmd_wdata = '0;
    cmd_hold  = 1'b0;
    rnd       = 32'h7e90;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    `CHK(crystal_halt, 1'b1)
    rd(ADDR_SECONDS, SEC_RESET);
    rd(ADDR_CONTROL, CTRL_RESET);
    rd(ADDR_DAYS, DAYS_RESET);
    rnd = lfsr_next(rnd);
    rd({3'b000, rnd[15:0]}, 8'h00);
    do_cmd(1'b1, ADDR_DAYS, 8'h41, 1'b0, 10'h100);
    // Both sign values and random magnitudes, with the freeze bit random.
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr_next(rnd);
      ctl_v = {1'b0, rnd[6], i[0], rnd[4:0]};
      wr(ADDR_CONTROL, ctl_v);
      rd(ADDR_CONTROL, ctl_v);
    end
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_SECONDS, 8'h81);
    wr(ADDR_DAYS, 8'h41);
    wr(ADDR_CONTROL, 8'h00);
    // The oscillator is halted, so the tone bit sits at zero.
    rd(ADDR_SECONDS, 8'h80);
    wr(ADDR_CONTROL, 8'h40);
    rd(ADDR_SECONDS, 8'h81);
    // Time-set release has loaded the written seconds into the counter.
    `CHK(sec_cnt, 7'h01)
    `CHK(sec_pulse, 1'b0)
    wr(ADDR_CONTROL, 8'h00);
    do_cmd(1'b0, ADDR_SECONDS, 8'h00, 1'b1, 10'h280);
    while (exp_q.size() != 0) @(negedge core_clk);
    repeat (5) @(negedge core_clk);
    `CHK(bus_if.dev_dq_oe, 1'b1)
    `CHK(data_line_zero, 1'b0)
    cmd_hold = 1'b0;
    wr(ADDR_DAYS, 8'h01);
    rd(ADDR_SECONDS, 8'h81);
    while (exp_q.size() != 0) @(negedge core_clk);
    repeat (20) @(negedge core_clk);
    report_and_stop();
  end
endmodule : rcs_tb
